// ==== verilog/gio_io_logic.sv ====
// Operation
// RL1 - Single rate: pad to bit 0; double rate: rising bit 0, falling bit 1.
// RL2 - Core drives bit 0 single rate; double rate launches bit 0 rising, bit 1 falling.
// RL3 - Core output enable reaches the pad driver, optionally through a register.
// RL4 - Output data and enable registers run on the launch clock.
// RL5 - Capture registers run on the independent capture clock.
// RL6 - With no register option, pad routes directly to a selectable alternate net.
// RL7 - Double rate uses both edges and exchanges a two-bit word per cycle.
// RL8 - Normal double rate hands each bit over at its own edge.
// RL9 - Resync double rate exchanges both bits with the core on rising edge only.
// RL10 - Resync input delays the falling sample half a cycle to join the rising one.
// RL11 - Double rate only on capable pins; others fall back to single rate.
// RL12 - Each register picks rising or falling edge; paths registered independently.
// RL13 - The registered output value may be inverted before the pad driver.
// RL14 - The alternate input path is combinational and never registered.
// RL15 - Pad driver is on while effective enable is high, released otherwise.
module gio_io_logic
  import gio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic CAPTURE_CLOCK,
  input wire logic LAUNCH_CLOCK,
  input wire logic DOUBLE_RATE_MODE,
  input wire logic RESYNC_MODE,
  input wire logic DDR_CAPABLE,
  input wire logic IN_REG_EN,
  input wire logic OUT_REG_EN,
  input wire logic OE_REG_EN,
  input wire logic IN_FALL_SEL,
  input wire logic OUT_FALL_SEL,
  input wire logic OE_FALL_SEL,
  input wire logic OUT_INVERT,
  input wire gio_bypass_dest_t BYPASS_DEST,
  input wire logic [1:0] OUT_DATA,
  input wire logic OE_IN,
  input wire logic PAD_I,
  output logic PAD_O,
  output logic PAD_OE,
  output logic [1:0] IN_DATA,
  output logic BYPASS_INPUT,
  output logic GLOBAL_CLOCK_NET,
  output logic GLOBAL_CONTROL_NET,
  output logic SYNTH_REFERENCE_INPUT,
  output logic CAMERA_LINK_CLOCK_INPUT
);

  logic cap_rise;
  logic cap_fall;
  logic lau_rise;
  logic lau_fall;
  logic fall_sample;
  logic fall_launch;
  logic [1:0] next_in_data;
  logic next_pad_o;
  logic next_pad_oe;
  logic next_fall_sample;
  logic next_fall_launch;

  // After reset a clock input that is already high is taken as a rise, so
  // the first captured or launched bit may come one clock edge early.
  gio_edge u_capture_edge
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .level(CAPTURE_CLOCK),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  gio_edge u_launch_edge
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .ce(CLK_EN),
    .level(LAUNCH_CLOCK),
    .rise(lau_rise),
    .fall(lau_fall)
  );

  // A pin without double-rate registers silently runs single rate.
  wire ddr_on = DOUBLE_RATE_MODE & DDR_CAPABLE; // RL11
  wire resync_on = ddr_on & RESYNC_MODE;
  wire normal_ddr = ddr_on & ~RESYNC_MODE;

  wire in_edge = IN_FALL_SEL ? cap_fall : cap_rise; // RL12 RL5
  wire out_edge = OUT_FALL_SEL ? lau_fall : lau_rise; // RL12 RL4
  wire oe_edge = OE_FALL_SEL ? lau_fall : lau_rise; // RL12 RL4

  // Single-rate paths either follow every reference edge or wait for the
  // selected clock edge; a clock faster than half the reference is lost.
  wire sdr_in_take = !IN_REG_EN || in_edge;
  wire sdr_out_take = !OUT_REG_EN || out_edge;
  // Output enable keeps its single-rate edge choice in double rate too,
  // so with OE_REG_EN set the driver switches at most once per launch period.
  wire oe_take = !OE_REG_EN || oe_edge;

  // Launch values carry the optional inversion already applied.
  wire rise_out_val = OUT_DATA[GIO_RISE_BIT] ^ OUT_INVERT;
  wire fall_out_val = OUT_DATA[GIO_FALL_BIT] ^ OUT_INVERT;
  wire held_out_val = fall_launch ^ OUT_INVERT;

  // Normal double rate hands each bit over at the edge that sampled it, so
  // the core must read the word after either capture edge.

  // Input path.
  always_comb
  begin
    next_in_data = IN_DATA;
    next_fall_sample = fall_sample;
    if (!ddr_on)
    begin
      if (sdr_in_take)
        next_in_data[GIO_RISE_BIT] = PAD_I; // RL1
    end
    else if (normal_ddr)
    begin
      if (cap_rise)
        next_in_data[GIO_RISE_BIT] = PAD_I; // RL1 RL8
      if (cap_fall)
        next_in_data[GIO_FALL_BIT] = PAD_I; // RL1 RL8
    end
    else
    begin
      // The falling sample waits half a cycle so both bits move together.
      if (cap_fall)
        next_fall_sample = PAD_I; // RL10
      if (cap_rise)
        next_in_data = {fall_sample, PAD_I}; // RL9 RL10 RL7
    end
  end

  // Output path; inversion is applied where the value is launched.
  always_comb
  begin
    next_pad_o = PAD_O;
    next_fall_launch = fall_launch;
    if (!ddr_on)
    begin
      if (sdr_out_take)
        next_pad_o = rise_out_val; // RL2 RL13
    end
    else if (normal_ddr)
    begin
      if (lau_rise)
        next_pad_o = rise_out_val; // RL2 RL8 RL13
      else if (lau_fall)
        next_pad_o = fall_out_val; // RL2 RL8 RL13
    end
    else
    begin
      // Both bits are taken at the rising edge; the second waits for the
      // falling edge, trading half a cycle of latency for one core edge.
      if (lau_rise)
      begin
        next_pad_o = rise_out_val; // RL9 RL7 RL13
        next_fall_launch = OUT_DATA[GIO_FALL_BIT]; // RL9
      end
      else if (lau_fall)
        next_pad_o = held_out_val; // RL2 RL9 RL13
    end
  end

  assign next_pad_oe = oe_take ? OE_IN : PAD_OE; // RL3

  // Capture side: the core word and the resync holding bit.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      IN_DATA <= GIO_IN_DATA_RESET;
      fall_sample <= GIO_HOLD_RESET;
    end
    else if (CLK_EN)
    begin
      IN_DATA <= next_in_data;
      fall_sample <= next_fall_sample;
    end
  end

  // Launch side: the pad value and the resync second bit.
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      PAD_O <= GIO_PAD_OUT_RESET;
      fall_launch <= GIO_HOLD_RESET;
    end
    else if (CLK_EN)
    begin
      PAD_O <= next_pad_o;
      fall_launch <= next_fall_launch;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      PAD_OE <= GIO_PAD_OE_RESET;
    else if (CLK_EN)
      PAD_OE <= next_pad_oe; // RL15
  end

  // The alternate path feeds clock networks, so it stays free of any
  // register; it is offered only when the input register and double rate are both off.
  wire bypass_on = ~IN_REG_EN & ~ddr_on; // RL6
  wire bypass_val = bypass_on & PAD_I; // RL14

  assign BYPASS_INPUT = bypass_val; // RL14
  // One-hot destination decode; only the selected net follows the pad.
  wire to_clock = BYPASS_DEST == GIO_DEST_GLOBAL_CLOCK;
  wire to_control = BYPASS_DEST == GIO_DEST_GLOBAL_CONTROL;
  wire to_synth = BYPASS_DEST == GIO_DEST_SYNTH_REF;
  wire to_camera = BYPASS_DEST == GIO_DEST_CAMERA_CLOCK;

  assign GLOBAL_CLOCK_NET = bypass_val & to_clock; // RL6
  assign GLOBAL_CONTROL_NET = bypass_val & to_control; // RL6
  assign SYNTH_REFERENCE_INPUT = bypass_val & to_synth; // RL6
  assign CAMERA_LINK_CLOCK_INPUT = bypass_val & to_camera; // RL6

endmodule

// ==== verilog/gio_pkg.sv ====
package gio_pkg;

  // Destination of the unregistered alternate input path.
  typedef enum logic [1:0]
  {
    GIO_DEST_GLOBAL_CLOCK = 2'b00,
    GIO_DEST_GLOBAL_CONTROL = 2'b01,
    GIO_DEST_SYNTH_REF = 2'b10,
    GIO_DEST_CAMERA_CLOCK = 2'b11
  } gio_bypass_dest_t;

  localparam logic [1:0] GIO_IN_DATA_RESET = 2'h0;
  localparam logic GIO_PAD_OUT_RESET = 1'h0;
  localparam logic GIO_PAD_OE_RESET = 1'h0;
  localparam logic GIO_HOLD_RESET = 1'h0;
  localparam logic GIO_LEVEL_RESET = 1'h0;

  // Bit positions inside the two-bit core words.
  localparam int GIO_RISE_BIT = 0;
  localparam int GIO_FALL_BIT = 1;

endpackage

// ==== verilog/gio_edge.sv ====
module gio_edge
  import gio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic level,
  output logic rise,
  output logic fall
);

  logic last;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      last <= GIO_LEVEL_RESET;
    else if (ce)
      last <= level;
  end

  assign rise = ce & level & ~last;
  assign fall = ce & ~level & last;

endmodule

// ==== tb/gio_far_model.sv ====
module gio_far_model (
  input wire logic clk,
  output logic cap_clk,
  output logic out_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph = 2'h0;
  always_ff @(posedge clk) ph <= ph + 2'h1;
  // Quarter rate keeps every clock level visible for two samples.
  assign cap_clk = ph[1];
  assign out_clk = ph[0] ^ ph[1];
endmodule

// ==== tb/gio_io_logic_asserts.sv ====
module gio_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic CAPTURE_CLOCK,
  input wire logic LAUNCH_CLOCK,
  input wire logic DOUBLE_RATE_MODE,
  input wire logic RESYNC_MODE,
  input wire logic DDR_CAPABLE,
  input wire logic IN_REG_EN,
  input wire logic OE_REG_EN,
  input wire logic OUT_REG_EN,
  input wire logic OUT_INVERT,
  input wire logic [1:0] OUT_DATA,
  input wire logic OE_IN,
  input wire logic PAD_I,
  input wire logic PAD_O,
  input wire logic PAD_OE,
  input wire logic [1:0] IN_DATA,
  input wire logic BYPASS_INPUT
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cp;
  logic lp;
  logic lh;
  wire dr = DOUBLE_RATE_MODE & DDR_CAPABLE;
  wire cr = CLK_EN & CAPTURE_CLOCK & ~cp;
  wire cf = CLK_EN & ~CAPTURE_CLOCK & cp;
  wire lr = CLK_EN & LAUNCH_CLOCK & ~lp;
  wire lf = CLK_EN & ~LAUNCH_CLOCK & lp;
  always_ff @(posedge REF_CLK)
    if (!RST_N) lp <= 1'h0;
    else if (CLK_EN) lp <= LAUNCH_CLOCK;
  always_ff @(posedge REF_CLK)
    if (!RST_N) lh <= 1'h0;
    else if (dr && RESYNC_MODE && lr) lh <= OUT_DATA[1];
  always_ff @(posedge REF_CLK)
    if (!RST_N) cp <= 1'h0;
    else if (CLK_EN) cp <= CAPTURE_CLOCK;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rsfall;
    dr && RESYNC_MODE && cf;
  endsequence
  sequence s_rsrise;
    dr && RESYNC_MODE && lr;
  endsequence
  sequence s_rslaunchfall;
    dr && RESYNC_MODE && lf;
  endsequence
  AST_BYP: assert property (
    BYPASS_INPUT == (PAD_I & ~IN_REG_EN & ~dr)) else $error("byp");
  AST_SIN: assert property (CLK_EN && !IN_REG_EN && !dr |=>
    IN_DATA[0] == $past(PAD_I)) else $error("sin");
  AST_SOE: assert property (CLK_EN && !OE_REG_EN |=>
    PAD_OE == $past(OE_IN)) else $error("soe");
  AST_DRISE: assert property (dr && cr |=>
    IN_DATA[0] == $past(PAD_I)) else $error("drise");
  AST_NFALL: assert property (dr && !RESYNC_MODE && cf |=>
    IN_DATA[1] == $past(PAD_I)) else $error("nfall");
  AST_RSHOLD: assert property (s_rsfall |=> $stable(IN_DATA))
    else $error("rshold");
  AST_CAPREG: assert property (IN_REG_EN && !dr && !cr && !cf |=>
    $stable(IN_DATA)) else $error("capreg");
  AST_SREG: assert property (DOUBLE_RATE_MODE && !DDR_CAPABLE |=>
    $stable(IN_DATA[1])) else $error("sreg");
  AST_OSDR: assert property (CLK_EN && !dr && !OUT_REG_EN |=>
    PAD_O == ($past(OUT_DATA[0]) ^ $past(OUT_INVERT))) else $error("osdr");
  AST_ONRISE: assert property (dr && !RESYNC_MODE && lr |=>
    PAD_O == ($past(OUT_DATA[0]) ^ $past(OUT_INVERT))) else $error("onrise");
  AST_ONFALL: assert property (dr && !RESYNC_MODE && lf |=>
    PAD_O == ($past(OUT_DATA[1]) ^ $past(OUT_INVERT))) else $error("onfall");
  AST_ORSRISE: assert property (s_rsrise |=>
    PAD_O == ($past(OUT_DATA[0]) ^ $past(OUT_INVERT))) else $error("orsrise");
  AST_ORSFALL: assert property (s_rslaunchfall |=>
    PAD_O == ($past(lh) ^ $past(OUT_INVERT))) else $error("orsfall");
endmodule
bind gio_io_logic gio_chk u_chk (.*);

// ==== tb/gio_io_logic_double_rate_mode_tb.sv ====
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module gio_io_logic_double_rate_mode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] cfg = 12'hc00;
  logic pi = 1'h1;
  gio_pkg::gio_bypass_dest_t bd = gio_pkg::GIO_DEST_GLOBAL_CLOCK;
  logic cc, lc, po, poe, byp;
  logic [1:0] id;
  logic [1:0] od = 2'h1;
  logic pr, pf;
  logic [3:0] net;
  int error_cnt = 0;
  int checks_done = 0;
  gio_far_model far (.clk(clk), .cap_clk(cc), .out_clk(lc));
  gio_io_logic dut (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(cfg[10]),
    .CAPTURE_CLOCK(cc), .LAUNCH_CLOCK(lc), .DOUBLE_RATE_MODE(cfg[9]),
    .RESYNC_MODE(cfg[8]), .DDR_CAPABLE(cfg[7]), .IN_REG_EN(cfg[6]),
    .OUT_REG_EN(cfg[5]), .OE_REG_EN(cfg[4]), .IN_FALL_SEL(cfg[3]),
    .OUT_FALL_SEL(cfg[2]), .OE_FALL_SEL(cfg[1]), .OUT_INVERT(cfg[0]),
    .BYPASS_DEST(bd), .OUT_DATA(od), .OE_IN(cfg[11]), .PAD_I(pi),
    .PAD_O(po), .PAD_OE(poe), .IN_DATA(id), .BYPASS_INPUT(byp),
    .GLOBAL_CLOCK_NET(net[0]), .GLOBAL_CONTROL_NET(net[1]),
    .SYNTH_REFERENCE_INPUT(net[2]), .CAMERA_LINK_CLOCK_INPUT(net[3]));
  initial
    forever #20 clk = ~clk;
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic write_cfg(input logic [11:0] c, input logic p,
    input logic [1:0] o);
    @(posedge clk);
    cfg <= c;
    pi <= p;
    od <= o;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask
  // Pad value after the design has seen a launch rise, then a launch fall.
  task automatic launch_pair(output logic r, output logic f);
    @(posedge lc);
    repeat (2) @(negedge clk);
    r = po;
    @(negedge lc);
    repeat (2) @(negedge clk);
    f = po;
  endtask
  initial
  begin
    repeat (500) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    write_cfg(12'hc00, 1'h1, 2'h1);
    `CHK({id, po, poe}, 4'h7)
    repeat (4)
    begin
      `CHK(net, 4'h1 << bd)
      @(posedge clk);
      bd <= bd.next();
      @(negedge clk);
    end
    write_cfg(12'h450, 1'h0, 2'h1);
    `CHK({id, byp, poe}, 4'h0)
    write_cfg(12'h448, 1'h1, 2'h1);
    `CHK(id, 2'h1)
    write_cfg(12'hf80, 1'h1, 2'h1);
    `CHK(id, 2'h3)
    launch_pair(pr, pf);
    `CHK({pr, pf}, 2'h2)
    write_cfg(12'he81, 1'h0, 2'h1);
    `CHK(id, 2'h0)
    launch_pair(pr, pf);
    `CHK({pr, pf}, 2'h1)
    write_cfg(12'he00, 1'h1, 2'h2);
    `CHK(id, 2'h1)
    launch_pair(pr, pf);
    `CHK({pr, pf}, 2'h0)
    print_verdict();
  end
endmodule
